// ===== samc_pkg.sv
// Constants and decode helpers for the serial converter control block.
// Assumes a single 100 MHz reference clock shared by all users.
`default_nettype none
package samc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ    = 100;
  localparam int CHAN_ON_NS = 1000; // Channel switch-on delay, ns
  localparam int ON_CYC     = (CHAN_ON_NS * CLK_MHZ + 999) / 1000;
  // ----------------------------------------
  // Widths, counts and field positions
  // ----------------------------------------
  localparam int RES_W      = 12;
  localparam int CHW_W      = 4;
  localparam int NCH        = 8;
  localparam int EN_POS     = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 15;
  localparam int CNT_W      = 16;
  localparam logic [1:0] END_SMPL_FALL = 2'h1; // Second falling edge
  localparam logic [3:0] MSB_IDX = 4'hB;
  localparam logic [3:0] TAIL_END = 4'hC;
  localparam logic [3:0] CONV_CYC = 4'hC;
  // ----------------------------------------
  // Reset values and pin slots
  // ----------------------------------------
  localparam logic [5:0] PIN_RST = 6'h0C; // Both selects idle high
  localparam logic [3:0] CHW_RST = 4'h0;
  localparam int P_SCLK = 0;
  localparam int P_DIN  = 1;
  localparam int P_MUX  = 2;
  localparam int P_CONV = 3;
  localparam int P_CMP  = 4;
  localparam int P_V8   = 5;

  typedef enum logic [1:0] {CV_OFF, CV_ACQ, CV_CONV, CV_TAIL} samc_cv_t;

  // Channel word to one-hot switch drive; enable bit low means all off
  function automatic logic [NCH-1:0] samc_chan_dec(
    input logic [CHW_W-1:0] w,
    input logic             eight
  );
    logic [2:0] a;
    a = eight ? w[2:0] : {1'b0, w[1:0]};
    samc_chan_dec = w[EN_POS] ? (8'h01 << a) : 8'h00;
  endfunction
endpackage
`default_nettype wire

// ===== samc_fifo.sv
// Result FIFO with parameterised width and depth.
// Assumes both sides run on ref_clk; ready and valid are combinational.
`timescale 1ns/10ps
`default_nettype none
module samc_fifo #(
  parameter int W = 15,
  parameter int D = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Honest full and empty from the fill count
  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];

  // Storage has no reset; only the pointers and the fill count need one
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== samc_ctrl.sv
// Control logic of a 12-bit sampling converter with 4/8-input multiplexer.
// Assumes all link pins are asynchronous to ref_clk and the shift clock
// is far slower than ref_clk, so it is oversampled as a plain input.
//
// What this block does
// - three bits after the enable bit choose the converted channel
// - selected channel is measured against the common negative input
// - enable low turns all channels off; four-input mode ignores bit two
// - eight-input mode decodes address bits as binary channel zero to seven
// - result codes are straight unipolar binary, never inverted
// - shared wire driven from second falling edge after select low, before sixth falling edge
// - mux and converter selects work independently for repeated conversions
// - converter draws power only while its select is low
// - after conversion, comparator and reference off; tail bits still shift
// - select high powers converter down; mux word still shifts in
// - sampling runs from switch-on delay to second falling clock edge
// - that falling edge puts sample-and-hold in hold and starts conversion
// - conversion takes exactly twelve shift-clock cycles
// - channel register keeps only the last four bits before select falls
// - bits change on falling edges and are captured on rising edges
// - one null bit precedes the first result bit
// - converter select high deselects, powers down, releases data output
`timescale 1ns/10ps
`default_nettype none
module samc_ctrl (
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic               shift_clk_pin,
  input  wire logic               din_pin,
  input  wire logic               mux_select_n,
  input  wire logic               conv_select_n,
  input  wire logic               comp_in,
  input  wire logic               variant_8ch,
  output logic                    dout_o,
  output logic                    dout_oe,
  output logic [samc_pkg::NCH-1:0] chan_enable,
  output logic                    sample_o,
  output logic                    hold_o,
  output logic                    conv_power_o,
  output logic                    ref_connect_o,
  output logic [samc_pkg::RES_W-1:0] sar_trial_o,
  output logic                    res_valid,
  input  wire logic               res_ready,
  output logic [2:0]              res_chan,
  output logic [samc_pkg::RES_W-1:0] res_data
);
  import samc_pkg::*;

  logic [5:0]       m1_q;
  logic [5:0]       m2_q;
  logic [5:0]       m3_q;
  logic [5:0]       lv_q;
  logic [5:0]       agree;
  logic             sclk_rise;
  logic             sclk_fall;
  logic [CHW_W-1:0] chw_sr_q;
  logic [CHW_W-1:0] chw_q;
  logic [CNT_W-1:0] mux_cnt_q;
  logic [CNT_W-1:0] acq_cnt_q;
  samc_cv_t         state_q;
  logic [1:0]       fall_cnt_q;
  logic [3:0]       bit_q;
  logic [3:0]       cf_q;
  logic [RES_W-1:0] res_q;
  logic             pend_q;
  logic             fifo_rdy;
  logic             conv_end;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // A level counts only once stages two and three agree
  assign agree = ~(m2_q ^ m3_q);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      m1_q <= PIN_RST;
      m2_q <= PIN_RST;
      m3_q <= PIN_RST;
      lv_q <= PIN_RST;
    end else begin
      m1_q <= {variant_8ch, comp_in, conv_select_n, mux_select_n,
               din_pin, shift_clk_pin};
      m2_q <= m1_q;
      m3_q <= m2_q;
      lv_q <= (m2_q & agree) | (lv_q & ~agree);
    end
  end

  assign sclk_rise = agree[P_SCLK] && m2_q[P_SCLK] && !lv_q[P_SCLK];
  assign sclk_fall = agree[P_SCLK] && !m2_q[P_SCLK] && lv_q[P_SCLK];

  // ----------------------------------------
  // Multiplexer side
  // ----------------------------------------
  // Shifting never depends on the converter select
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chw_sr_q <= CHW_RST;
    end else if (sclk_rise && lv_q[P_MUX]) begin
      chw_sr_q <= {chw_sr_q[CHW_W-2:0], lv_q[P_DIN]};
    end
  end

  // Word latched on select fall; extra early bits already shifted out
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chw_q <= CHW_RST;
    end else if (lv_q[P_MUX] && agree[P_MUX] && !m2_q[P_MUX]) begin
      chw_q <= chw_sr_q;
    end
  end

  // Break before make: all off, then selected on after the delay
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mux_cnt_q   <= CNT_W'(ON_CYC);
      chan_enable <= '0;
    end else if (lv_q[P_MUX]) begin
      mux_cnt_q   <= CNT_W'(ON_CYC);
      chan_enable <= '0;
    end else begin
      if (mux_cnt_q != '0) begin
        mux_cnt_q <= mux_cnt_q - 1'b1;
      end
      chan_enable <= (mux_cnt_q == '0) ?
                     samc_chan_dec(chw_q, lv_q[P_V8]) : '0;
    end
  end

  a_chan_enable_bit: assert property (
    (chan_enable != '0) |-> chw_q[EN_POS] && $onehot(chan_enable)
  ) else $error("channel on with enable bit low");

  a_break_make: assert property (
    $fell(lv_q[P_MUX]) |=> (chan_enable == '0) [*8]
  ) else $error("channel on before switch-on delay");

  a_shift_last: assert property (
    sclk_rise && lv_q[P_MUX] |=> chw_sr_q[0] == $past(lv_q[P_DIN])
  ) else $error("channel shift lost a bit");

  // ----------------------------------------
  // Converter sequencer
  // ----------------------------------------
  // A pending result blocks a new cycle, so a full FIFO stalls conversions
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= CV_OFF;
    end else if (lv_q[P_CONV]) begin
      state_q <= CV_OFF;
    end else begin
      case (state_q)
        CV_OFF: begin
          // No new cycle while a result waits or the FIFO has no room
          if (!pend_q && fifo_rdy) begin
            state_q <= CV_ACQ;
          end
        end
        CV_ACQ: begin
          if (sclk_fall && fall_cnt_q == END_SMPL_FALL) begin
            state_q <= CV_CONV;
          end
        end
        CV_CONV: begin
          if (sclk_fall && bit_q == '0) begin
            state_q <= CV_TAIL;
          end
        end
        default: state_q <= CV_TAIL;
      endcase
    end
  end

  // Falling edges and switch-on delay seen while acquiring
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fall_cnt_q <= '0;
      acq_cnt_q  <= CNT_W'(ON_CYC);
    end else if (state_q != CV_ACQ) begin
      fall_cnt_q <= '0;
      acq_cnt_q  <= CNT_W'(ON_CYC);
    end else begin
      if (sclk_fall) begin
        fall_cnt_q <= fall_cnt_q + 1'b1;
      end
      if (acq_cnt_q != '0) begin
        acq_cnt_q <= acq_cnt_q - 1'b1;
      end
    end
  end

  assign conv_end = (state_q == CV_CONV) && sclk_fall && bit_q == '0;

  // Analog controls decoded from state; capacitor bottom plate sits on
  // the negative input in hold, so the result is relative to it
  assign sample_o      = (state_q == CV_ACQ) && acq_cnt_q == '0;
  assign hold_o        = (state_q == CV_CONV);
  assign conv_power_o  = (state_q == CV_ACQ) || (state_q == CV_CONV);
  assign ref_connect_o = conv_power_o;
  assign sar_trial_o   = hold_o ? (res_q | (12'h001 << bit_q)) : '0;

  // Select high takes one cycle to reach the state, hence the next cycle
  a_tail_power: assert property (
    (state_q == CV_TAIL) || lv_q[P_CONV] |=> !conv_power_o && !ref_connect_o
  ) else $error("converter powered outside conversion");

  a_no_sample_hold: assert property (
    $rose(state_q == CV_CONV) |-> !sample_o && fall_cnt_q == 2'h2
  ) else $error("sampling overlaps hold");

  // ----------------------------------------
  // Serial output and SAR register
  // ----------------------------------------
  // Every output change while selected sits on a shift-clock falling edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_o  <= 1'b0;
      dout_oe <= 1'b0;
      res_q   <= '0;
      bit_q   <= MSB_IDX;
    end else if (lv_q[P_CONV]) begin
      dout_o  <= 1'b0;
      dout_oe <= 1'b0;
      res_q   <= '0;
      bit_q   <= MSB_IDX;
    end else if (sclk_fall) begin
      case (state_q)
        CV_ACQ: begin
          if (fall_cnt_q == END_SMPL_FALL) begin
            dout_oe <= 1'b1;
            dout_o  <= 1'b0;
          end
        end
        CV_CONV: begin
          res_q[bit_q] <= lv_q[P_CMP];
          dout_o       <= lv_q[P_CMP];
          bit_q <= (bit_q == '0) ? 4'h1 : bit_q - 1'b1;
        end
        CV_TAIL: begin
          if (bit_q != TAIL_END) begin
            dout_o <= res_q[bit_q];
            bit_q  <= bit_q + 1'b1;
          end else begin
            dout_o <= 1'b0;
          end
        end
        default: dout_o <= 1'b0;
      endcase
    end
  end

  a_null_bit: assert property (
    (state_q == CV_ACQ) && sclk_fall && fall_cnt_q == END_SMPL_FALL
    |=> dout_oe && !dout_o && state_q == CV_CONV
  ) else $error("missing null bit or hold");

  a_release_dout: assert property (
    lv_q[P_CONV] |=> !dout_oe
  ) else $error("data output driven while deselected");

  // Helper: falling edges spent converting
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cf_q <= '0;
    end else if (state_q == CV_ACQ) begin
      cf_q <= '0;
    end else if (state_q == CV_CONV && sclk_fall) begin
      cf_q <= cf_q + 1'b1;
    end
  end

  a_conv_twelve: assert property (
    $rose(state_q == CV_TAIL) |-> cf_q == CONV_CYC
  ) else $error("conversion not twelve cycles");

  // ----------------------------------------
  // Result hand-off
  // ----------------------------------------
  // Set wins over clear, though both cannot meet in one cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= conv_end || (pend_q && !fifo_rdy);
    end
  end

  samc_fifo #(
    .W (FIFO_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_valid  (pend_q),
    .in_ready  (fifo_rdy),
    .in_data   ({chw_q[2:0], res_q}),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  ({res_chan, res_data})
  );
endmodule
`default_nettype wire

// ===== samc_host.sv
// Host model: shift clock, both selects and its side of the shared wire.
// Assumes the bench resolves the shared wire from both enables.
`timescale 1ns/10ps
`default_nettype none
module samc_host (
  input  wire logic  ref_clk,
  input  wire logic  data_w,
  output logic       sclk,
  output logic       mux_sel_n,
  output logic       conv_sel_n,
  output logic       host_d,
  output logic       host_oe,
  output logic [5:0] fall_no
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    sclk = 1'b0; // Clock stands still between frames
    mux_sel_n = 1'b1;
    conv_sel_n = 1'b1;
    host_d = 1'b0;
    host_oe = 1'b0;
    fall_no = 6'h00;
  end

  // Pins move a fixed 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Word shift with selects high, then selects low and a read-back
  task automatic frame(input logic [7:0] bits, input int n,
                       input logic mux, input logic conv,
                       output logic [31:0] rx);
    rx = '0;
    fall_no = 6'h00;
    if (n > 0) mux_sel_n = 1'b1;
    if (n > 0) host_oe = 1'b1; // Host drives only while selects are high
    for (int i = n - 1; i >= 0; i--) begin
      host_d = bits[i]; // New bit after the falling edge
      tick(8);
      sclk = 1'b1;
      tick(8);
      sclk = 1'b0;
    end
    if (n > 0) host_oe = 1'b0; // Released before the selects fall
    if (mux) mux_sel_n = 1'b0;
    conv_sel_n = !conv;
    tick(110);
    for (int k = 1; k <= 28; k++) begin
      sclk = 1'b1;
      tick(8);
      sclk = 1'b0;
      tick(8);
      rx[k] = data_w; // Level the next rising edge takes
      fall_no = 6'(k);
    end
    tick(4);
    conv_sel_n = 1'b1;
    tick(20);
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the converter control block.
// Assumes the shared data wire ties host and block data pins together.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import samc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic variant_8ch = 1'b1;
  logic res_ready = 1'b0;
  logic tog = 1'b0;
  logic exp_run = 1'b0;
  logic sclk, mux_sel_n, conv_sel_n, host_d, host_oe, data_w, comp_in;
  logic dout_o, dout_oe, sample_o, hold_o, conv_power_o, ref_connect_o;
  logic res_valid;
  logic [NCH-1:0] chan_enable;
  logic [RES_W-1:0] sar_trial_o, res_data, vin;
  logic [RES_W-1:0] neg = 12'h000;
  logic [2:0] res_chan;
  logic [5:0] fall_no;
  logic [31:0] rx;
  logic [RES_W-1:0] ain [8] = '{12'h000, 12'hFFF, 12'h5A3, 12'h001,
                                12'hA5C, 12'h7FF, 12'h810, 12'h3C0};
  logic [14:0] exp_q [$];
  int err_count = 0;
  int checks = 0;

  // ----------------------------------------
  // Clock, shared wire and comparator
  // ----------------------------------------
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tog <= ~tog;
  // Released wire shows a changing pattern, not a stale bit
  assign data_w = dout_oe ? dout_o : host_oe ? host_d : tog;
  // Switched channel measured against the negative input
  always_comb begin
    vin = 12'h000;
    for (int i = 0; i < NCH; i++) if (chan_enable[i]) vin = ain[i] - neg;
  end
  assign comp_in = (vin >= sar_trial_o);

  samc_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .shift_clk_pin(sclk),
    .din_pin(data_w), .mux_select_n(mux_sel_n),
    .conv_select_n(conv_sel_n), .comp_in(comp_in),
    .variant_8ch(variant_8ch), .dout_o(dout_o), .dout_oe(dout_oe),
    .chan_enable(chan_enable), .sample_o(sample_o), .hold_o(hold_o),
    .conv_power_o(conv_power_o), .ref_connect_o(ref_connect_o),
    .sar_trial_o(sar_trial_o), .res_valid(res_valid),
    .res_ready(res_ready), .res_chan(res_chan), .res_data(res_data));

  samc_host host (.ref_clk(ref_clk), .data_w(data_w), .sclk(sclk),
    .mux_sel_n(mux_sel_n), .conv_sel_n(conv_sel_n), .host_d(host_d),
    .host_oe(host_oe), .fall_no(fall_no));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [14:0] seen,
                       input logic [14:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Phase checks at chosen falling edges of each frame
  always @(fall_no) begin
    if (fall_no == 6'h01) check("sampling", sample_o, exp_run);
    if (fall_no == 6'h03) check("hold", hold_o, exp_run);
    if (fall_no == 6'h03) check("sample_end", sample_o, 1'b0);
    if (fall_no == 6'h05) check("drive", dout_oe, exp_run);
    if (fall_no == 6'h0D) check("converting", conv_power_o, exp_run);
    if (fall_no == 6'h0E) check("comp_off", conv_power_o, 1'b0);
    if (fall_no == 6'h0E) check("ref_off", ref_connect_o, 1'b0);
  end

  // Both parties on the wire at once is a clash
  always @(posedge ref_clk) if (dout_oe && host_oe) check("clash", 1, 0);

  // One conversion; expected stream worked out from the analog model
  task automatic conv_ch(input logic [2:0] ch, input logic [7:0] bits,
                         input int n);
    logic [RES_W-1:0] code;
    code = ain[ch] - neg;
    exp_run = 1'b1;
    host.frame(bits, n, 1'b1, 1'b1, rx);
    check("chan_on", chan_enable, 8'h01 << ch);
    check("null_bit", rx[2], 1'b0);
    for (int k = 3; k <= 14; k++) check("msb_first", rx[k], code[14-k]);
    for (int k = 15; k <= 25; k++) check("lsb_tail", rx[k], code[k-14]);
    for (int k = 26; k <= 28; k++) check("zeros", rx[k], 1'b0);
    check("released", dout_oe, 1'b0);
    check("powered_down", conv_power_o, 1'b0);
    exp_q.push_back({ch, code});
  endtask

  // Pops every queued result with the consumer stalling in between
  task automatic drain();
    logic [14:0] e;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("res_valid", res_valid, 1'b1);
      check("res_data", res_data, e[11:0]);
      check("res_chan", res_chan, e[14:12]);
      res_ready = 1'b1;
      host.tick(1);
      res_ready = 1'b0;
      host.tick(3);
    end
    check("empty", res_valid, 1'b0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    host.tick(3);
    check("rst_oe", dout_oe, 1'b0);
    check("rst_chan", chan_enable, 8'h00);
    check("rst_valid", res_valid, 1'b0);
    rst_b = 1'b1;
    host.tick(4);
    // Every address while the consumer stalls fills the FIFO
    for (int c = 0; c < 8; c++) begin
      neg = (c == 6) ? 12'h010 : 12'h000; // Raised negative input
      conv_ch(3'(c), {5'h01, 3'(c)}, 4);
    end
    // Full FIFO: the next request must not start
    exp_run = 1'b0;
    host.frame(8'h0A, 4, 1'b1, 1'b1, rx);
    check("full_valid", res_valid, 1'b1);
    drain();
    variant_8ch = 1'b0;
    host.frame(8'h0E, 4, 1'b1, 1'b0, rx);
    check("four_in", chan_enable, 8'h04);
    host.frame(8'h05, 4, 1'b1, 1'b0, rx);
    check("all_off", chan_enable, 8'h00);
    variant_8ch = 1'b1;
    // Six bits shifted with the converter deselected
    host.frame(8'h1B, 6, 1'b1, 1'b0, rx);
    check("last_four", chan_enable, 8'h08);
    neg = 12'h000;
    // Channel kept, converter selected alone twice
    conv_ch(3'h3, 8'h00, 0);
    conv_ch(3'h3, 8'h00, 0);
    drain();
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
